/* rtl/sys_power_pkg.sv */
package sys_power_pkg;
	// register indices; byte address is four times the index
	localparam logic [31:0] IDX_PMU = 32'h5000_0010;
	localparam logic [31:0] IDX_SYS = 32'h5000_0012;
	localparam logic [31:0] IDX_STAT = 32'h5000_0014;
	localparam logic [31:0] IDX_TRIM = 32'h5000_0016;
	localparam logic [31:0] IDX_FTRIM = 32'h5000_0018;
	localparam logic [31:0] IDX_CLK32 = 32'h5000_0020;
	// reset values and writable masks
	localparam logic [15:0] PMU_RST = 16'h0006;
	localparam logic [15:0] PMU_MASK = 16'h0037;
	localparam logic [15:0] SYS_RST = 16'h0020;
	localparam logic [15:0] SYS_MASK = 16'h02FF;
	localparam logic [7:0] TRIM_RST = 8'hA2;
	localparam logic [15:0] FTRIM_RST = 16'h0000;
	localparam logic [15:0] CLK32_RST = 16'h079C;
	localparam logic [15:0] CLK32_MASK = 16'h1FFF;
	// field positions
	localparam int PMU_COPY_DIV = 4;
	localparam int PMU_RADIO = 2;
	localparam int PMU_PERIPH = 1;
	localparam int PMU_WAKE_RST = 0;
	localparam int SYS_SWRST = 15;
	localparam int SYS_TMO_DIS = 9;
	localparam int SYS_DBG = 7;
	localparam int SYS_PROM_RST = 6;
	localparam int SYS_PAD = 5;
	localparam int SYS_COPY = 4;
	localparam int SYS_SRC = 3;
	localparam int SYS_RET = 2;
	localparam int SYS_REMAP = 0;
	localparam int TRIM_TIME = 4;
	localparam int TRIM_SETTLE = 0;
	localparam int C32_AMP = 12;
	localparam int C32_TRIM = 8;
	localparam int C32_RC_EN = 7;
	localparam int C32_CUR = 3;
	localparam int C32_RBIAS = 1;
	localparam int C32_XT_EN = 0;
	// timing
	localparam int CLK_MHZ = 100;
	localparam int RC_MHZ = 16;
	localparam int STEP_US = 250;
	localparam int RC_DIV = STEP_US * RC_MHZ;
	localparam int TIMEOUT_US = 2000;
	localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
	localparam int RESET_CYC = 16;
	localparam int COPY_WORDS = 64;
	// state encodings
	typedef enum logic [2:0] {PWR_RUN, PWR_SLEEP, PWR_WAKE, PWR_COPY}
		pwr_state_t;
	typedef enum logic [1:0] {XT_OFF, XT_TRIM, XT_SETTLE, XT_DONE}
		xtal_state_t;
endpackage : sys_power_pkg

/* rtl/system_power_clock_control.sv */
// Chosen here: the APB register port.
`timescale 1ns/1ps
// Contract
// - copy divider field divides bus clock while prom is mirrored to ram
// - radio sleep bit holds radio logic powered down; resets to one
// - peripheral sleep bit powers down all peripherals; resets to one
// - reset-after-wakeup bit gives full reset on wake, then boot
// - software reset bit resets all but system control and freq trim
// - power sequencer proceeds after 2 ms unless timeout disabled
// - debugger enable bit; clear frees debug pins as gpio
// - controller reset request bit resets prom controller
// - pad latch enable zero holds pads; one is transparent; resets one
// - copy enable bit copies prom into system ram after wakeup
// - slow source select: zero rc oscillator, one crystal
// - retention bit keeps system domain powered; copy only if enabled
// - remap field picks memory at address zero
// - settled flag set only after crystal settle time
// - trim ready flag when applied trim equals programmed; resets one
// - up and down flags per domain; down resets one, up zero
// - trim delay field, 250 us steps, zero immediate, resets 0xA
// - settle delay field, 250 us steps, zero immediate, resets 0x2
// - 250 us step is fast rc clock divided by 4000
// - slow rc trim field, lowest 0x0 to highest 0xF, resets 0x7
// - slow rc enable resets one; slow crystal enable resets zero
module system_power_clock_control import sys_power_pkg::*; #(
	parameter int ADDR_W = 12,
	parameter int TIMEOUT = TIMEOUT_CYC,
	parameter int RST_LEN = RESET_CYC,
	parameter int WORDS = COPY_WORDS
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// power sequencing
	input wire logic sleep_request,
	input wire logic wakeup_event,
	input wire logic blocks_ready,
	input wire logic [2:0] domain_power_ok,
	output logic radio_power_down,
	output logic peripheral_power_down,
	output logic system_power_domain_off,
	output logic device_reset,
	output logic boot_start,
	output logic copy_active,
	output logic copy_step,
	// system control outputs
	output logic prom_controller_reset_request,
	output logic pad_latch_enable,
	output logic debugger_enable,
	output logic slow_clock_source_select,
	output logic [1:0] address_zero_remap,
	// fast crystal trimming
	input wire logic fast_rc_oscillator,
	input wire logic fast_crystal_enable,
	output logic [15:0] crystal_trim_value,
	// slow clock control
	output logic slow_crystal_amplitude_reg_off,
	output logic [3:0] slow_rc_trim,
	output logic slow_rc_enable,
	output logic slow_crystal_enable,
	output logic [3:0] slow_crystal_bias,
	output logic [1:0] slow_crystal_rbias
);
	localparam int TW = $clog2(TIMEOUT + 1);
	localparam int RW = $clog2(RST_LEN + 1);
	localparam int WW = $clog2(WORDS + 1);
	localparam int DW = $clog2(RC_DIV);

	// refuse settings the logic cannot serve
	if (ADDR_W < 8 || TIMEOUT < 1 || RST_LEN < 1 || WORDS < 1) begin : g_chk
		$error("system_power_clock_control: bad parameter");
	end

	logic [15:0] pmu_reg, sys_reg, ftrim_reg, clk32_reg;
	logic [7:0] trim_reg;
	logic pready_reg, pslverr_reg;
	logic [31:0] prdata_reg;
	logic [RW-1:0] rst_cnt_reg;
	logic rst_full_reg, boot_reg, dev_rst_reg;
	logic [1:0] wake_meta, wake_sync, ready_meta, ready_sync;
	logic [2:0] dom_meta, dom_sync;
	logic rc_meta, rc_sync, rc_prev;
	logic [DW-1:0] rc_cnt_reg;
	logic step_tick_reg;
	pwr_state_t pwr_state;
	logic [TW-1:0] tmo_cnt_reg;
	logic [2:0] div_cnt_reg;
	logic [WW-1:0] words_reg;
	logic copy_step_reg, sys_off_reg, radio_pd_reg, periph_pd_reg;
	logic copy_active_reg;
	logic [5:0] dom_flags_reg;
	xtal_state_t xt_state;
	logic [3:0] step_cnt_reg;
	logic [15:0] applied_reg;
	logic settled_reg, trim_ready_reg;
	logic acc, wr, hit, rst_active, full_rst, part_rst, wake_done;
	logic [9:0] idx;

	// apb decode; a write lands on the edge that samples pready high
	assign idx = 10'(paddr[ADDR_W-1:2]);
	assign acc = psel & penable;
	assign wr = acc & pready_reg & pwrite & ~pslverr_reg;
	assign hit = idx == IDX_PMU[9:0] || idx == IDX_SYS[9:0] ||
		idx == IDX_STAT[9:0] || idx == IDX_TRIM[9:0] ||
		idx == IDX_FTRIM[9:0] || idx == IDX_CLK32[9:0];

	// internal reset pulse: full for wake reset, partial for software
	assign rst_active = rst_cnt_reg != '0;
	assign full_rst = sys_rst | (rst_active & rst_full_reg);
	assign part_rst = sys_rst | rst_active;
	assign wake_done = pwr_state == PWR_WAKE &&
		(ready_sync[1] || (!sys_reg[SYS_TMO_DIS] &&
		tmo_cnt_reg == TW'(TIMEOUT - 1)));

	// apb answer one cycle into the access phase
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= '0;
		end else begin
			pready_reg <= acc & ~pready_reg;
			pslverr_reg <= acc & ~pready_reg & ~hit;
			if (acc & ~pready_reg & ~pwrite) begin
				unique case (idx)
					IDX_PMU[9:0]: prdata_reg <= {16'h0000, pmu_reg};
					IDX_SYS[9:0]: prdata_reg <= {16'h0000, sys_reg};
					IDX_STAT[9:0]: prdata_reg <= {24'h00_0000, settled_reg,
						trim_ready_reg, dom_flags_reg};
					IDX_TRIM[9:0]: prdata_reg <= {24'h00_0000, trim_reg};
					IDX_FTRIM[9:0]: prdata_reg <= {16'h0000, ftrim_reg};
					IDX_CLK32[9:0]: prdata_reg <= {16'h0000, clk32_reg};
					default: prdata_reg <= '0;
				endcase
			end
		end
	end

	// reset pulse generator, software or wake triggered
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rst_cnt_reg <= '0;
			rst_full_reg <= 1'b0;
			boot_reg <= 1'b0;
			dev_rst_reg <= 1'b0;
		end else begin
			boot_reg <= rst_cnt_reg == RW'(1) && rst_full_reg;
			dev_rst_reg <= rst_active;
			if (wake_done && pmu_reg[PMU_WAKE_RST]) begin
				rst_cnt_reg <= RW'(RST_LEN);
				rst_full_reg <= 1'b1;
			end else if (wr && idx == IDX_SYS[9:0] && pwdata[SYS_SWRST]) begin
				rst_cnt_reg <= RW'(RST_LEN);
				rst_full_reg <= 1'b0;
			end else if (rst_active) begin
				rst_cnt_reg <= rst_cnt_reg - RW'(1);
			end
		end
	end

	// system control survives software reset; reset bit never stored
	always_ff @(posedge sys_clk) begin
		if (full_rst) begin
			sys_reg <= SYS_RST;
			ftrim_reg <= FTRIM_RST;
		end else if (wr && idx == IDX_SYS[9:0]) begin
			sys_reg <= pwdata[15:0] & SYS_MASK;
		end else if (wr && idx == IDX_FTRIM[9:0]) begin
			ftrim_reg <= pwdata[15:0];
		end
	end

	// registers cleared by any internal reset
	always_ff @(posedge sys_clk) begin
		if (part_rst) begin
			pmu_reg <= PMU_RST;
			trim_reg <= TRIM_RST;
			clk32_reg <= CLK32_RST;
		end else if (wr) begin
			if (idx == IDX_PMU[9:0])
				pmu_reg <= pwdata[15:0] & PMU_MASK;
			if (idx == IDX_TRIM[9:0])
				trim_reg <= pwdata[7:0];
			if (idx == IDX_CLK32[9:0])
				clk32_reg <= pwdata[15:0] & CLK32_MASK;
		end
	end

	// synchronisers for pins from other domains
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			wake_meta <= '0;
			wake_sync <= '0;
			ready_meta <= '0;
			ready_sync <= '0;
			dom_meta <= '0;
			dom_sync <= '0;
			rc_meta <= 1'b0;
			rc_sync <= 1'b0;
			rc_prev <= 1'b0;
		end else begin
			wake_meta <= {wake_meta[0], wakeup_event};
			wake_sync <= {wake_sync[0], wake_meta[1]};
			ready_meta <= {ready_meta[0], blocks_ready};
			ready_sync <= {ready_sync[0], ready_meta[1]};
			dom_meta <= domain_power_ok;
			dom_sync <= dom_meta;
			rc_meta <= fast_rc_oscillator;
			rc_sync <= rc_meta;
			rc_prev <= rc_sync;
		end
	end

	// 250 us step from fast rc edges
	always_ff @(posedge sys_clk) begin
		if (part_rst) begin
			rc_cnt_reg <= '0;
			step_tick_reg <= 1'b0;
		end else begin
			step_tick_reg <= 1'b0;
			if (rc_sync & ~rc_prev) begin
				if (rc_cnt_reg == DW'(RC_DIV - 1)) begin
					rc_cnt_reg <= '0;
					step_tick_reg <= 1'b1;
				end else begin
					rc_cnt_reg <= rc_cnt_reg + DW'(1);
				end
			end
		end
	end

	// power sequencer: sleep, wake with timeout, optional ram copy
	always_ff @(posedge sys_clk) begin
		if (part_rst) begin
			pwr_state <= PWR_RUN;
			tmo_cnt_reg <= '0;
			div_cnt_reg <= '0;
			words_reg <= '0;
			copy_step_reg <= 1'b0;
			copy_active_reg <= 1'b0;
		end else begin
			copy_step_reg <= 1'b0;
			unique case (pwr_state)
				PWR_RUN: if (sleep_request) begin
					pwr_state <= PWR_SLEEP;
				end
				PWR_SLEEP: if (wake_sync[1]) begin
					pwr_state <= PWR_WAKE;
					tmo_cnt_reg <= '0;
				end
				PWR_WAKE: begin
					tmo_cnt_reg <= tmo_cnt_reg + TW'(1);
					if (wake_done) begin
						if (pmu_reg[PMU_WAKE_RST]) begin
							pwr_state <= PWR_RUN;
						end else if (sys_reg[SYS_COPY]) begin
							pwr_state <= PWR_COPY;
							copy_active_reg <= 1'b1;
							div_cnt_reg <= '0;
							words_reg <= WW'(WORDS);
						end else begin
							pwr_state <= PWR_RUN;
						end
					end
				end
				PWR_COPY: begin
					if (div_cnt_reg ==
						3'((4'd1 << pmu_reg[PMU_COPY_DIV+:2]) - 4'd1)) begin
						div_cnt_reg <= '0;
						copy_step_reg <= 1'b1;
						words_reg <= words_reg - WW'(1);
						if (words_reg == WW'(1)) begin
							pwr_state <= PWR_RUN;
							copy_active_reg <= 1'b0;
						end
					end else begin
						div_cnt_reg <= div_cnt_reg + 3'd1;
					end
				end
				default: begin
					pwr_state <= PWR_RUN;
					copy_active_reg <= 1'b0;
				end
			endcase
		end
	end

	// domain power controls and status flags
	always_ff @(posedge sys_clk) begin
		if (part_rst) begin
			radio_pd_reg <= 1'b1;
			periph_pd_reg <= 1'b1;
			sys_off_reg <= 1'b0;
			dom_flags_reg <= 6'b01_0101;
		end else begin
			radio_pd_reg <= pmu_reg[PMU_RADIO] | pwr_state == PWR_SLEEP;
			periph_pd_reg <= pmu_reg[PMU_PERIPH] | pwr_state == PWR_SLEEP;
			sys_off_reg <= pwr_state == PWR_SLEEP & ~sys_reg[SYS_RET];
			dom_flags_reg <= {
				dom_sync[2] & sys_reg[SYS_DBG], ~dom_sync[2],
				dom_sync[1] & ~periph_pd_reg, ~dom_sync[1],
				dom_sync[0] & ~radio_pd_reg, ~dom_sync[0]};
		end
	end

	// crystal trim sequencer: trim delay, apply, settle delay
	always_ff @(posedge sys_clk) begin
		if (part_rst) begin
			xt_state <= XT_OFF;
			step_cnt_reg <= '0;
			applied_reg <= FTRIM_RST;
			settled_reg <= 1'b0;
			trim_ready_reg <= 1'b1;
		end else begin
			trim_ready_reg <= applied_reg == ftrim_reg;
			if (!fast_crystal_enable) begin
				xt_state <= XT_OFF;
				settled_reg <= 1'b0;
			end else begin
				unique case (xt_state)
					XT_OFF: begin
						xt_state <= XT_TRIM;
						step_cnt_reg <= trim_reg[TRIM_TIME+:4];
					end
					XT_TRIM: if (step_cnt_reg == 4'd0) begin
						applied_reg <= ftrim_reg;
						step_cnt_reg <= trim_reg[TRIM_SETTLE+:4];
						xt_state <= XT_SETTLE;
					end else if (step_tick_reg) begin
						step_cnt_reg <= step_cnt_reg - 4'd1;
					end
					XT_SETTLE: if (step_cnt_reg == 4'd0) begin
						settled_reg <= 1'b1;
						xt_state <= XT_DONE;
					end else if (step_tick_reg) begin
						step_cnt_reg <= step_cnt_reg - 4'd1;
					end
					XT_DONE: applied_reg <= ftrim_reg;
				endcase
			end
		end
	end

	// port drive from registers
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign radio_power_down = radio_pd_reg;
	assign peripheral_power_down = periph_pd_reg;
	assign system_power_domain_off = sys_off_reg;
	assign device_reset = dev_rst_reg;
	assign boot_start = boot_reg;
	assign copy_active = copy_active_reg; // tracks copy state, registered
	assign copy_step = copy_step_reg;
	assign prom_controller_reset_request = sys_reg[SYS_PROM_RST];
	assign pad_latch_enable = sys_reg[SYS_PAD];
	assign debugger_enable = sys_reg[SYS_DBG];
	assign slow_clock_source_select = sys_reg[SYS_SRC];
	assign address_zero_remap = sys_reg[SYS_REMAP+:2];
	assign crystal_trim_value = applied_reg;
	assign slow_crystal_amplitude_reg_off = clk32_reg[C32_AMP];
	assign slow_rc_trim = clk32_reg[C32_TRIM+:4];
	assign slow_rc_enable = clk32_reg[C32_RC_EN];
	assign slow_crystal_enable = clk32_reg[C32_XT_EN];
	assign slow_crystal_bias = clk32_reg[C32_CUR+:4];
	assign slow_crystal_rbias = clk32_reg[C32_RBIAS+:2];

	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (part_rst);

	sequence s_copy_half;
		!copy_step_reg ##1 copy_step_reg;
	endsequence
	a_copy_div_two: assert property (
		pwr_state == PWR_COPY && copy_step_reg && words_reg > WW'(1) &&
		pmu_reg[PMU_COPY_DIV+:2] == 2'd1 && !wr |=> s_copy_half)
		else $error("copy step not every second cycle");
	a_radio_held: assert property (
		pmu_reg[PMU_RADIO] |=> radio_pd_reg)
		else $error("radio not held down");
	a_periph_held: assert property (
		pmu_reg[PMU_PERIPH] ##1 pmu_reg[PMU_PERIPH] |-> periph_pd_reg)
		else $error("peripherals not held down");
	a_wake_reset: assert property (
		disable iff (sys_rst)
		wake_done && pmu_reg[PMU_WAKE_RST] |=> ##1 dev_rst_reg)
		else $error("no reset after wakeup");
	a_swrst_pulse: assert property (
		disable iff (sys_rst)
		wr && idx == IDX_SYS[9:0] && pwdata[SYS_SWRST] |=> ##1 dev_rst_reg)
		else $error("software reset not issued");
	a_wake_timeout: assert property (
		pwr_state == PWR_WAKE && !sys_reg[SYS_TMO_DIS] &&
		tmo_cnt_reg == TW'(TIMEOUT - 1) |=> pwr_state != PWR_WAKE)
		else $error("wake timeout missed");
	a_settle_set: assert property (
		xt_state == XT_SETTLE && step_cnt_reg == 4'd0 && fast_crystal_enable
		|=> settled_reg)
		else $error("settled flag late");
	a_settled_off: assert property (
		!fast_crystal_enable |=> !settled_reg)
		else $error("settled without crystal");
	a_trim_match: assert property (
		!$past(part_rst) && $stable(applied_reg) && $stable(ftrim_reg) |->
		trim_ready_reg == (applied_reg == ftrim_reg))
		else $error("trim ready wrong");
	a_swrst_reads: assert property (
		pready_reg && !pwrite && idx == IDX_SYS[9:0] |-> !prdata_reg[15])
		else $error("reset bit reads one");
	a_rad_down: assert property (
		!dom_sync[0] |=> dom_flags_reg[0] && !dom_flags_reg[1])
		else $error("radio down flag wrong");
endmodule : system_power_clock_control

/* test/testbench.sv */
`timescale 1ns/1ps
module testbench import sys_power_pkg::*;;
	localparam int T_OUT = 50;
	localparam int R_LEN = 4;
	localparam int N_WORDS = 4;
	localparam logic [31:0] ALL = 32'hFFFF_FFFF;
	localparam logic [11:0] A_PMU = {IDX_PMU[9:0], 2'b00};
	localparam logic [11:0] A_SYS = {IDX_SYS[9:0], 2'b00};
	localparam logic [11:0] A_STAT = {IDX_STAT[9:0], 2'b00};
	localparam logic [11:0] A_TRIM = {IDX_TRIM[9:0], 2'b00};
	localparam logic [11:0] A_FT = {IDX_FTRIM[9:0], 2'b00};
	localparam logic [11:0] A_C32 = {IDX_CLK32[9:0], 2'b00};
	logic sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic sleep_request, wakeup_event, blocks_ready, fast_rc_oscillator;
	logic [2:0] domain_power_ok;
	logic radio_power_down, peripheral_power_down, system_power_domain_off;
	logic device_reset, boot_start, copy_active, copy_step, er;
	logic prom_controller_reset_request, pad_latch_enable, debugger_enable;
	logic slow_clock_source_select, fast_crystal_enable;
	logic [1:0] address_zero_remap, slow_crystal_rbias;
	logic [15:0] crystal_trim_value;
	logic slow_crystal_amplitude_reg_off, slow_rc_enable, slow_crystal_enable;
	logic [3:0] slow_rc_trim, slow_crystal_bias;
	int mismatches = 0;
	int compares = 0;
	int cyc = 0;
	int steps = 0;
	int gap = 0;
	int last = 0;
	int boots = 0;
	int n, s0;

	system_power_clock_control #(.TIMEOUT(T_OUT), .RST_LEN(R_LEN),
		.WORDS(N_WORDS)) system_power_clock_control_i (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sleep_request(sleep_request),
		.wakeup_event(wakeup_event), .blocks_ready(blocks_ready),
		.domain_power_ok(domain_power_ok),
		.radio_power_down(radio_power_down),
		.peripheral_power_down(peripheral_power_down),
		.system_power_domain_off(system_power_domain_off),
		.device_reset(device_reset), .boot_start(boot_start),
		.copy_active(copy_active), .copy_step(copy_step),
		.prom_controller_reset_request(prom_controller_reset_request),
		.pad_latch_enable(pad_latch_enable),
		.debugger_enable(debugger_enable),
		.slow_clock_source_select(slow_clock_source_select),
		.address_zero_remap(address_zero_remap),
		.fast_rc_oscillator(fast_rc_oscillator),
		.fast_crystal_enable(fast_crystal_enable),
		.crystal_trim_value(crystal_trim_value),
		.slow_crystal_amplitude_reg_off(slow_crystal_amplitude_reg_off),
		.slow_rc_trim(slow_rc_trim), .slow_rc_enable(slow_rc_enable),
		.slow_crystal_enable(slow_crystal_enable),
		.slow_crystal_bias(slow_crystal_bias),
		.slow_crystal_rbias(slow_crystal_rbias));

	// clocks: system 100 MHz, fast rc 16 MHz
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		fast_rc_oscillator = 1'b0;
		forever #31.25 fast_rc_oscillator = ~fast_rc_oscillator;
	end

	// cycle count, copy pulse spacing and boot pulses
	always @(posedge sys_clk) cyc <= cyc + 1;
	always @(negedge sys_clk) begin
		if (copy_step === 1'b1) begin
			steps <= steps + 1;
			gap <= cyc - last;
			last <= cyc;
		end
		if (boot_start === 1'b1) boots <= boots + 1;
	end

	task automatic print_verdict();
		if (mismatches == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : print_verdict

	task automatic give_up();
		mismatches++;
		print_verdict();
	endtask : give_up

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic settle(input int k);
		repeat (k) @(negedge sys_clk);
	endtask : settle

	// one apb transfer; holds the request until pready is seen
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		// sample pready, data and error at the rising edge itself
		@(posedge sys_clk);
		while (pready !== 1'b1) begin
			k++;
			if (k > 20) give_up();
			@(posedge sys_clk);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rdck(input logic [11:0] a, input logic [31:0] m,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		check(rd & m, e);
	endtask : rdck

	// sleep, then wake; returns cycles until copy or reset starts
	task automatic power_cycle(input logic off, input int lim);
		@(posedge sys_clk);
		sleep_request <= 1'b1;
		@(posedge sys_clk);
		sleep_request <= 1'b0;
		settle(3);
		check({radio_power_down, peripheral_power_down,
			system_power_domain_off}, {2'b11, off});
		@(posedge sys_clk);
		wakeup_event <= 1'b1;
		n = 0;
		@(negedge sys_clk);
		while (copy_active !== 1'b1 && device_reset !== 1'b1 && n < lim) begin
			n++;
			@(negedge sys_clk);
		end
		@(posedge sys_clk);
		wakeup_event <= 1'b0;
	endtask : power_cycle

	// main sequence
	initial begin
		sys_rst = 1'b1;
		{psel, penable, pwrite, sleep_request, wakeup_event} = '0;
		{blocks_ready, fast_crystal_enable} = '0;
		paddr = '0;
		pwdata = '0;
		domain_power_ok = '0;
		repeat (16) @(posedge sys_clk);
		sys_rst <= 1'b0;
		settle(2);
		check({radio_power_down, peripheral_power_down, pad_latch_enable,
			device_reset, debugger_enable}, 5'b11100);
		check({slow_rc_trim, slow_rc_enable, slow_crystal_enable,
			address_zero_remap}, {4'h7, 4'b1000});
		rdck(A_PMU, ALL, {16'h0000, PMU_RST});
		rdck(A_SYS, ALL, {16'h0000, SYS_RST});
		rdck(A_STAT, ALL, 32'h0000_0055);
		rdck(A_TRIM, ALL, {24'h00_0000, TRIM_RST});
		rdck(A_C32, ALL, {16'h0000, CLK32_RST});
		// masks, read-only status and unmapped place
		wr(A_PMU, ALL);
		rdck(A_PMU, ALL, {16'h0000, PMU_MASK});
		wr(A_PMU, 32'h0000_0000);
		settle(2);
		check({radio_power_down, peripheral_power_down}, 2'b00);
		for (int r = 0; r < 4; r++) begin
			wr(A_SYS, r);
			settle(1);
			check(address_zero_remap, r);
		end
		wr(A_SYS, 32'h0000_7FFF);
		rdck(A_SYS, ALL, {16'h0000, SYS_MASK});
		check({debugger_enable, prom_controller_reset_request,
			pad_latch_enable, slow_clock_source_select}, 4'hF);
		wr(A_SYS, 32'h0000_0000);
		settle(1);
		check({debugger_enable, prom_controller_reset_request,
			pad_latch_enable, slow_clock_source_select}, 4'h0);
		wr(A_C32, 32'h0000_1A5B);
		settle(1);
		check({slow_crystal_amplitude_reg_off, slow_rc_trim, slow_rc_enable,
			slow_crystal_bias, slow_crystal_rbias, slow_crystal_enable},
			32'h0000_1A5B);
		wr(A_TRIM, ALL);
		rdck(A_TRIM, ALL, 32'h0000_00FF);
		wr(A_FT, 32'h0000_ABCD);
		rdck(A_FT, ALL, 32'h0000_ABCD);
		check(er, 1'b0);
		wr(A_STAT, ALL);
		rdck(A_STAT, 32'h0000_003F, 32'h0000_0015);
		wr(12'h044, ALL);
		check(er, 1'b1);
		rdck(12'h044, ALL, 32'h0000_0000);
		check(er, 1'b1);
		// domain flags follow power and requests
		wr(A_SYS, 32'h0000_0080);
		domain_power_ok <= 3'b111;
		settle(5);
		rdck(A_STAT, 32'h0000_003F, 32'h0000_002A);
		wr(A_PMU, 32'h0000_0004);
		domain_power_ok <= 3'b110; // radio domain follows its request
		settle(3);
		rdck(A_STAT, 32'h0000_0003, 32'h0000_0001);
		// software reset spares system control and frequency trim
		wr(A_SYS, 32'h0000_8083);
		n = 0;
		while (device_reset !== 1'b1 && n < 10) begin
			n++;
			settle(1);
		end
		check(device_reset, 1'b1);
		settle(R_LEN + 6);
		rdck(A_SYS, ALL, 32'h0000_0083);
		rdck(A_FT, ALL, 32'h0000_ABCD);
		rdck(A_PMU, ALL, {16'h0000, PMU_RST});
		rdck(A_C32, ALL, {16'h0000, CLK32_RST});
		rdck(A_TRIM, ALL, {24'h00_0000, TRIM_RST});
		// copy after wakeup at every divider setting
		blocks_ready <= 1'b1;
		wr(A_SYS, 32'h0000_0030);
		for (int dv = 0; dv < 4; dv++) begin
			wr(A_PMU, dv << 4);
			s0 = steps;
			power_cycle(1'b1, 40);
			check(copy_active, 1'b1);
			settle(100);
			check(steps - s0, N_WORDS);
			check(gap, 1 << dv);
			check(radio_power_down, 1'b0);
		end
		// wake ends on timeout, then not when timeout is disabled
		wr(A_PMU, 32'h0000_0000);
		blocks_ready <= 1'b0;
		power_cycle(1'b1, 200);
		check(n >= T_OUT && n <= T_OUT + 10, 1'b1);
		settle(60);
		wr(A_SYS, 32'h0000_0234);
		power_cycle(1'b0, 200);
		check(copy_active, 1'b0);
		blocks_ready <= 1'b1;
		settle(7);
		check(copy_active, 1'b1);
		settle(60);
		// reset after wakeup, then boot
		wr(A_PMU, 32'h0000_0001);
		wr(A_SYS, 32'h0000_0083);
		s0 = boots;
		power_cycle(1'b1, 40);
		n = 0;
		while (device_reset === 1'b1 && n < 50) begin
			n++;
			settle(1);
		end
		check(n, R_LEN);
		settle(10);
		check(boots - s0, 1);
		rdck(A_SYS, ALL, {16'h0000, SYS_RST});
		rdck(A_PMU, ALL, {16'h0000, PMU_RST});
		// crystal trim and settle with zero delays
		wr(A_FT, 32'h0000_0123);
		wr(A_TRIM, 32'h0000_0000);
		rdck(A_STAT, 32'h0000_0040, 32'h0000_0000);
		fast_crystal_enable <= 1'b1;
		settle(12);
		check(crystal_trim_value, 16'h0123);
		rdck(A_STAT, 32'h0000_00C0, 32'h0000_00C0);
		fast_crystal_enable <= 1'b0;
		settle(2);
		rdck(A_STAT, 32'h0000_0080, 32'h0000_0000);
		// two trim steps and one settle step of 4000 rc edges
		wr(A_FT, 32'h0000_0456);
		wr(A_TRIM, 32'h0000_0021);
		fast_crystal_enable <= 1'b1;
		s0 = cyc;
		while (crystal_trim_value !== 16'h0456 && cyc - s0 < 60000) settle(1);
		check(cyc - s0 >= 24990 && cyc - s0 <= 50010, 1'b1);
		s0 = cyc;
		rd = 32'h0000_0000;
		while (rd[7] !== 1'b1 && cyc - s0 < 30000) begin
			apb(1'b0, A_STAT, 32'h0000_0000);
		end
		check(cyc - s0 <= 25020, 1'b1);
		check(rd[7:6], 2'b11);
		print_verdict();
	end
endmodule : testbench
